// *** design/eca_defs.vh ***
/*
 * Constants of the event capture and alert block: register addresses,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef ECA_DEFS_VH
`define ECA_DEFS_VH

// ***************************************************************
// Register addresses (7-bit register address space)
// ***************************************************************
`define ECA_ADDR_SYS_CAPT_EN   7'h04
`define ECA_ADDR_SUP_CAPT_EN   7'h1C
`define ECA_ADDR_TRX_CAPT_EN   7'h23
`define ECA_ADDR_GLOBAL        7'h60
`define ECA_ADDR_SYS_FLAGS     7'h61
`define ECA_ADDR_SUP_FLAGS     7'h62
`define ECA_ADDR_TRX_FLAGS     7'h63

// ***************************************************************
// Field positions
// ***************************************************************
`define ECA_BIT_POWER_ON       4
`define ECA_BIT_OVERTEMP       2
`define ECA_BIT_SERIAL_FAIL    1
`define ECA_BIT_WDOG_FAIL      0
`define ECA_BIT_UNDERVOLT      0
`define ECA_BIT_BUS_SILENCE    4
`define ECA_BIT_TRX_FAIL       1
`define ECA_BIT_BUS_WAKEUP     0
`define ECA_BIT_GRP_TRX        2
`define ECA_BIT_GRP_SUP        1
`define ECA_BIT_GRP_SYS        0

// ***************************************************************
// Writable masks and reset values
// ***************************************************************
`define ECA_SYS_FLAG_MASK      8'h17
`define ECA_SUP_FLAG_MASK      8'h01
`define ECA_TRX_FLAG_MASK      8'h13
`define ECA_SYS_EN_MASK        8'h06
`define ECA_SUP_EN_MASK        8'h01
`define ECA_TRX_EN_MASK        8'h13
`define ECA_REG_RESET          8'h00

// ***************************************************************
// Serial access lengths and timing
// ***************************************************************
`define ECA_SPI_LEN_16         6'h10
`define ECA_SPI_LEN_24         6'h18
`define ECA_SPI_LEN_32         6'h20
`define ECA_EVT_DELAY_US       10
`define ECA_CLK_MHZ            100
`define ECA_EVT_DELAY_CYC      (`ECA_EVT_DELAY_US * `ECA_CLK_MHZ)
`define ECA_TMR_W              20

`endif

// *** design/eca_sync2.v ***
/*
 * Two flip-flop level synchroniser, one stage pair per bit.
 * Assumes the inputs are slow levels from pins or analog comparators.
 */
`timescale 1ns/1ps

module eca_sync2 #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             mclk_i,
   input  wire             arst_n_i,
   // Levels
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   // ***************************************************************
   // Per-bit synchroniser chain
   // ***************************************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         // First stage feeds only the second one
         always @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= async_i[g];
               sync_q <= meta_q;
            end
         end
         assign sync_o[g] = sync_q;
      end
   endgenerate

endmodule

// *** design/eca_delay_timer.v ***
/*
 * Event delay timer: counts a fixed number of clock cycles after a start,
 * reports running and a one-cycle expiry pulse, and halts on stop.
 * Assumes start and stop come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "eca_defs.vh"

module eca_delay_timer #(
   parameter DELAY_CYC = `ECA_EVT_DELAY_CYC
) (
   // Clock and reset
   input  wire mclk_i,
   input  wire arst_n_i,
   // Control
   input  wire start_i,
   input  wire stop_i,
   // Status
   output reg  running_o,
   output reg  expire_o
);

   // Last count cut to the counter width on purpose
   localparam integer          LAST_I = DELAY_CYC - 1;
   localparam [`ECA_TMR_W-1:0] LAST   = LAST_I[`ECA_TMR_W-1:0];

   reg [`ECA_TMR_W-1:0] cnt_q;

   // ***************************************************************
   // Counter; stop beats start so a reset-pin fall always halts it
   // ***************************************************************
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q     <= {`ECA_TMR_W{1'b0}};
         running_o <= 1'b0;
         expire_o  <= 1'b0;
      end else begin
         expire_o <= 1'b0;
         if (stop_i) begin
            running_o <= 1'b0;
            cnt_q     <= {`ECA_TMR_W{1'b0}};
         end else if (start_i) begin
            running_o <= 1'b1; // Restart on every clear that has no stop in the same cycle
            cnt_q     <= {`ECA_TMR_W{1'b0}};
         end else if (running_o) begin
            if (cnt_q == LAST) begin
               running_o <= 1'b0;
               expire_o  <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

endmodule

// *** design/eca_event_capture.v ***
/*
 * Event capture and receive-data alert of a CAN system basis chip:
 * sticky write-1-to-clear event flags with capture enables, a global
 * summary register, and the receive-data pin pull-down with delay timer.
 * Assumes the register port is driven by the serial frame logic on mclk_i
 * and event pulses come from logic on the same clock; pin and analog
 * levels are synchronised here.
 */
`timescale 1ns/1ps
`include "eca_defs.vh"

module eca_event_capture #(
   parameter EVT_DELAY_CYC = `ECA_EVT_DELAY_CYC
) (
   // Clock and reset
   input  wire       mclk_i,
   input  wire       arst_n_i,
   // Register port from the serial frame logic
   input  wire [6:0] reg_addr_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   input  wire [7:0] reg_wdata_i,
   output reg  [7:0] reg_rdata_o,
   // Serial access checks, valid with spi_done_i
   input  wire       spi_done_i,
   input  wire [5:0] spi_bit_count_i,
   input  wire       spi_bad_code_i,
   input  wire       spi_locked_wr_i,
   // System events
   input  wire       power_on_evt_i,
   input  wire       wd_overflow_i,
   input  wire       wd_early_trig_i,
   input  wire       wd_window_mode_i,
   input  wire       wd_timeout_mode_i,
   input  wire       overtemp_warn_i,
   // Supply and transceiver state
   input  wire       supply_below90_i,
   input  wire       supply_active_i,
   input  wire       bus_silent_i,
   input  wire       trx_uv_deact_i,
   input  wire       txd_dom_timeout_i,
   input  wire       wake_pattern_i,
   input  wire       trx_offline_i,
   input  wire       reset_output_pin_i,
   // Outputs
   output reg        rxd_drive_low_o,
   output reg        sys_reset_req_o
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   reg  [7:0] sys_en_q;
   reg  [7:0] sup_en_q;
   reg  [7:0] trx_en_q;
   reg  [7:0] sys_flags_q;
   reg  [7:0] sup_flags_q;
   reg  [7:0] trx_flags_q;
   reg  [7:0] sys_flags_d;
   reg  [7:0] sup_flags_d;
   reg  [7:0] trx_flags_d;
   reg  [7:0] sys_set;
   reg  [7:0] sup_set;
   reg  [7:0] trx_set;
   reg  [7:0] rdata_d;
   reg        ovt_prev_q;
   reg        uv_prev_q;
   reg        silent_prev_q;
   reg        rst_pin_prev_q;
   reg        silence_armed_q;
   reg        serial_fail;
   reg        wd_fail;
   reg        alert_d;
   wire [2:0] pin_sync;
   wire       ovt_s;
   wire       uv_s;
   wire       rst_pin_s;
   wire [7:0] sys_clr;
   wire [7:0] sup_clr;
   wire [7:0] trx_clr;
   wire       any_clr;
   wire       pending;
   wire       rst_pin_fall;
   wire       tmr_running;
   wire       tmr_expire;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   // Bits that a write to this address actually clears
   function [7:0] w1c_clear;
      input [6:0] addr;
      input [6:0] target;
      input       wr;
      input [7:0] wdata;
      input [7:0] mask;
      input [7:0] flags;
      begin
         w1c_clear = (wr && (addr == target)) ? (wdata & mask & flags) : 8'h00;
      end
   endfunction

   // ***************************************************************
   // Pin and analog level synchronisers
   // ***************************************************************
   eca_sync2 #(
      .WIDTH (3)
   ) u_sync (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .async_i  ({reset_output_pin_i, supply_below90_i, overtemp_warn_i}),
      .sync_o   (pin_sync)
   );

   assign ovt_s     = pin_sync[0];
   assign uv_s      = pin_sync[1];
   assign rst_pin_s = pin_sync[2];

   // ***************************************************************
   // Edge history and bus silence arming
   // ***************************************************************
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovt_prev_q      <= 1'b0;
         uv_prev_q       <= 1'b0;
         silent_prev_q   <= 1'b0;
         rst_pin_prev_q  <= 1'b0;
         silence_armed_q <= 1'b0;
      end else begin
         ovt_prev_q     <= ovt_s;
         uv_prev_q      <= uv_s;
         silent_prev_q  <= bus_silent_i;
         rst_pin_prev_q <= rst_pin_s;
         // Arms only when enabled during activity; disarms when enable drops
         if (!trx_en_q[`ECA_BIT_BUS_SILENCE])
            silence_armed_q <= 1'b0;
         else if (!bus_silent_i)
            silence_armed_q <= 1'b1;
      end
   end

   assign rst_pin_fall = rst_pin_prev_q & ~rst_pin_s;

   // ***************************************************************
   // Event sources
   // ***************************************************************
   always @* begin
      // Only the three frame lengths are legal
      serial_fail = spi_done_i &&
                    ((spi_bit_count_i != `ECA_SPI_LEN_16 &&
                      spi_bit_count_i != `ECA_SPI_LEN_24 &&
                      spi_bit_count_i != `ECA_SPI_LEN_32) ||
                     spi_bad_code_i || spi_locked_wr_i);
      wd_fail = (wd_overflow_i && (wd_window_mode_i || wd_timeout_mode_i)) ||
                (wd_early_trig_i && wd_window_mode_i);
      sys_set = 8'h00;
      sup_set = 8'h00;
      trx_set = 8'h00;
      sys_set[`ECA_BIT_POWER_ON]    = power_on_evt_i;
      sys_set[`ECA_BIT_WDOG_FAIL]   = wd_fail;
      sys_set[`ECA_BIT_OVERTEMP]    = ovt_s & ~ovt_prev_q &
                                      sys_en_q[`ECA_BIT_OVERTEMP];
      sys_set[`ECA_BIT_SERIAL_FAIL] = serial_fail &
                                      sys_en_q[`ECA_BIT_SERIAL_FAIL];
      // Threshold selection plays no part here, only the 90 percent level
      sup_set[`ECA_BIT_UNDERVOLT]   = uv_s & ~uv_prev_q & supply_active_i &
                                      sup_en_q[`ECA_BIT_UNDERVOLT];
      trx_set[`ECA_BIT_BUS_SILENCE] = bus_silent_i & ~silent_prev_q &
                                      silence_armed_q;
      trx_set[`ECA_BIT_TRX_FAIL]    = (trx_uv_deact_i | txd_dom_timeout_i) &
                                      trx_en_q[`ECA_BIT_TRX_FAIL];
      trx_set[`ECA_BIT_BUS_WAKEUP]  = wake_pattern_i & trx_offline_i &
                                      trx_en_q[`ECA_BIT_BUS_WAKEUP];
   end

   // ***************************************************************
   // Write-1-to-clear decoding
   // ***************************************************************
   assign sys_clr = w1c_clear(reg_addr_i, `ECA_ADDR_SYS_FLAGS, reg_wr_i, reg_wdata_i,
                              `ECA_SYS_FLAG_MASK, sys_flags_q);
   assign sup_clr = w1c_clear(reg_addr_i, `ECA_ADDR_SUP_FLAGS, reg_wr_i, reg_wdata_i,
                              `ECA_SUP_FLAG_MASK, sup_flags_q);
   assign trx_clr = w1c_clear(reg_addr_i, `ECA_ADDR_TRX_FLAGS, reg_wr_i, reg_wdata_i,
                              `ECA_TRX_FLAG_MASK, trx_flags_q);
   assign any_clr = |{sys_clr, sup_clr, trx_clr};

   // Set beats clear so an event landing on the clear write is kept
   always @* begin
      sys_flags_d = (sys_flags_q & ~sys_clr) | sys_set;
      sup_flags_d = (sup_flags_q & ~sup_clr) | sup_set;
      trx_flags_d = (trx_flags_q & ~trx_clr) | trx_set;
   end

   // ***************************************************************
   // Flag and enable registers
   // ***************************************************************
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sys_flags_q <= `ECA_REG_RESET;
         sup_flags_q <= `ECA_REG_RESET;
         trx_flags_q <= `ECA_REG_RESET;
         sys_en_q    <= `ECA_REG_RESET;
         sup_en_q    <= `ECA_REG_RESET;
         trx_en_q    <= `ECA_REG_RESET;
      end else begin
         sys_flags_q <= sys_flags_d;
         sup_flags_q <= sup_flags_d;
         trx_flags_q <= trx_flags_d;
         if (reg_wr_i && reg_addr_i == `ECA_ADDR_SYS_CAPT_EN)
            sys_en_q <= reg_wdata_i & `ECA_SYS_EN_MASK;
         if (reg_wr_i && reg_addr_i == `ECA_ADDR_SUP_CAPT_EN)
            sup_en_q <= reg_wdata_i & `ECA_SUP_EN_MASK;
         if (reg_wr_i && reg_addr_i == `ECA_ADDR_TRX_CAPT_EN)
            trx_en_q <= reg_wdata_i & `ECA_TRX_EN_MASK;
      end
   end

   // ***************************************************************
   // Watchdog reset request
   // ***************************************************************
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sys_reset_req_o <= 1'b0;
      end else begin
         // A timeout overflow resets only on a second failure in a row
         sys_reset_req_o <= (wd_window_mode_i && (wd_overflow_i || wd_early_trig_i)) ||
                            (wd_timeout_mode_i && wd_overflow_i &&
                             sys_flags_q[`ECA_BIT_WDOG_FAIL]);
      end
   end

   // ***************************************************************
   // Register read; reads have no side effects
   // ***************************************************************
   always @* begin
      case (reg_addr_i)
         `ECA_ADDR_SYS_CAPT_EN: rdata_d = sys_en_q;
         `ECA_ADDR_SUP_CAPT_EN: rdata_d = sup_en_q;
         `ECA_ADDR_TRX_CAPT_EN: rdata_d = trx_en_q;
         `ECA_ADDR_GLOBAL:      rdata_d = {5'h00, |trx_flags_q, |sup_flags_q,
                                           |sys_flags_q};
         `ECA_ADDR_SYS_FLAGS:   rdata_d = sys_flags_q;
         `ECA_ADDR_SUP_FLAGS:   rdata_d = sup_flags_q;
         `ECA_ADDR_TRX_FLAGS:   rdata_d = trx_flags_q;
         default:               rdata_d = 8'h00;
      endcase
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= rdata_d;
   end

   // ***************************************************************
   // Event delay timer
   // ***************************************************************
   eca_delay_timer #(
      .DELAY_CYC (EVT_DELAY_CYC)
   ) u_timer (
      .mclk_i    (mclk_i),
      .arst_n_i  (arst_n_i),
      .start_i   (any_clr),
      .stop_i    (rst_pin_fall),
      .running_o (tmr_running),
      .expire_o  (tmr_expire)
   );

   // ***************************************************************
   // Receive-data alert
   // ***************************************************************
   assign pending = |{sys_flags_d, sup_flags_d, trx_flags_d};

   // Expiry needs no branch: once stopped, pending with the offline and supply gates decides
   always @* begin
      if (any_clr || (tmr_running && !rst_pin_fall))
         alert_d = 1'b0;
      else
         alert_d = pending && trx_offline_i && supply_active_i;
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         rxd_drive_low_o <= 1'b0;
      else
         rxd_drive_low_o <= alert_d;
   end

endmodule

// *** bench/eca_event_capture_properties.sv ***
/*
 * Checker for the event capture block: watchdog reset requests, alert gating,
 * read port stability, reserved bits and the quiet time after a clear.
 * Assumes it is bound to eca_event_capture and sees its ports only.
 */
`timescale 1ns/1ps

module eca_event_capture_chk #(
   parameter EVT_DELAY_CYC = 8
) (
   // Clock and reset
   input wire       mclk_i,
   input wire       arst_n_i,
   // Register port
   input wire [6:0] reg_addr_i,
   input wire       reg_wr_i,
   input wire       reg_rd_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   // Watchdog and state
   input wire       wd_overflow_i,
   input wire       wd_early_trig_i,
   input wire       wd_window_mode_i,
   input wire       wd_timeout_mode_i,
   input wire       trx_offline_i,
   input wire       supply_active_i,
   input wire       reset_output_pin_i,
   // Outputs
   input wire       rxd_drive_low_o,
   input wire       sys_reset_req_o
);
   // ****************************************
   // Shadow of the watchdog failure flag
   // ****************************************
   logic wdg_q;
   logic wdg_d;
   wire  wdg_set = (wd_overflow_i && (wd_window_mode_i || wd_timeout_mode_i))
                   || (wd_early_trig_i && wd_window_mode_i);
   wire  wdg_clr = reg_wr_i && reg_addr_i == 7'h61 && reg_wdata_i[0];

   // Set beats clear, as in the flag logic
   always_comb wdg_d = wdg_set | (wdg_q & ~wdg_clr);
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) wdg_q <= 1'b0;
      else wdg_q <= wdg_d;
   end

   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_alert_on;
      trx_offline_i && supply_active_i && rxd_drive_low_o;
   endsequence
   sequence s_alert_off;
      trx_offline_i && supply_active_i && !rxd_drive_low_o && reset_output_pin_i;
   endsequence

   a_offline_gate: assert property (!(trx_offline_i && supply_active_i)
      |=> !rxd_drive_low_o)
      else $error("alert driven outside offline mode");
   a_window_reset: assert property (wd_window_mode_i
      && (wd_overflow_i || wd_early_trig_i) |=> sys_reset_req_o)
      else $error("no reset after window failure");
   a_reset_cause: assert property (!wdg_set |=> !sys_reset_req_o)
      else $error("reset request without watchdog failure");
   a_timeout_first: assert property (wd_timeout_mode_i && !wd_window_mode_i
      && wd_overflow_i && !wdg_q |=> !sys_reset_req_o)
      else $error("reset on first timeout overflow");
   a_timeout_again: assert property (wd_timeout_mode_i && wd_overflow_i
      && wdg_q |=> sys_reset_req_o)
      else $error("no reset on repeated timeout overflow");
   a_summary_rsvd: assert property (reg_rd_i && reg_addr_i == 7'h60
      |=> reg_rdata_o[7:3] == 5'h00)
      else $error("summary reserved bits set");
   a_sys_rsvd: assert property (reg_rd_i && reg_addr_i == 7'h61
      |=> reg_rdata_o[7:5] == 3'h0 && !reg_rdata_o[3])
      else $error("system flag reserved bits set");
   a_rdata_stable: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_delay_quiet: assert property (s_alert_on ##1 s_alert_off
      |=> (!rxd_drive_low_o || !reset_output_pin_i) [*6])
      else $error("alert returned while delay timer ran");
endmodule

bind eca_event_capture eca_event_capture_chk #(.EVT_DELAY_CYC(EVT_DELAY_CYC)) i_chk (
   .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .wd_overflow_i(wd_overflow_i), .wd_early_trig_i(wd_early_trig_i),
   .wd_window_mode_i(wd_window_mode_i), .wd_timeout_mode_i(wd_timeout_mode_i),
   .trx_offline_i(trx_offline_i), .supply_active_i(supply_active_i),
   .reset_output_pin_i(reset_output_pin_i), .rxd_drive_low_o(rxd_drive_low_o),
   .sys_reset_req_o(sys_reset_req_o));

// *** bench/eca_mcu_model.sv ***
/*
 * Microcontroller side: receive-data pin with pull-up, and the mask that
 * software uses to clear flags.
 * Assumes the bench feeds it the last value read from a status register.
 */
`timescale 1ns/1ps

module eca_mcu_model (
   // Alert pin
   input  wire       rxd_drive_low_i,
   output wire       rxd_pin_o,
   // Software view
   input  wire [7:0] seen_i,
   output wire [7:0] clear_mask_o
);
   // Pulled up; only the device pulls it low
   assign rxd_pin_o    = rxd_drive_low_i ? 1'b0 : 1'b1;
   // Clear only what was seen set, so late events survive
   assign clear_mask_o = seen_i;
endmodule

// *** bench/test_event_capture_and_rxd_alert.sv ***
/*
 * Self-checking bench of the event capture block through its register port.
 * Assumes a 100 MHz clock and a shortened event delay of 8 cycles.
 */
`timescale 1ns/1ps

module test_event_capture_and_rxd_alert;
   logic       mclk_i = 1'b0;
   logic       arst_n_i = 1'b0;
   logic [6:0] addr = 7'h00;
   logic       wr = 1'b0, rd = 1'b0, done = 1'b0, bad = 1'b0, lock = 1'b0;
   logic [7:0] wdata = 8'h00, seen = 8'h00;
   logic [5:0] cnt = 6'h10, ev = 6'h00;
   logic       wwin = 1'b0, wto = 1'b1, ovt = 1'b0, uv = 1'b0, sil = 1'b0, rpin = 1'b1;
   logic       act = 1'b1, off = 1'b1, req_seen = 1'b0;
   wire  [7:0] rdata, cmask;
   wire        drv, pin, rreq;
   int         n_mismatch = 0, n_compared = 0;
   logic [6:0] regs [8] = '{7'h04, 7'h1C, 7'h23, 7'h60, 7'h61, 7'h62, 7'h63, 7'h10};
   logic [7:0] en_exp [8] = '{8'h06, 8'h01, 8'h13, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [5:0] fc [6] = '{6'h10, 6'h18, 6'h20, 6'h14, 6'h10, 6'h20};

   // ****************************************
   // Design, partner and clock
   // ****************************************
   eca_event_capture #(.EVT_DELAY_CYC(8)) i_dut (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .spi_done_i(done),
      .spi_bit_count_i(cnt), .spi_bad_code_i(bad), .spi_locked_wr_i(lock),
      .power_on_evt_i(ev[5]), .wd_overflow_i(ev[4]), .wd_early_trig_i(ev[3]),
      .wd_window_mode_i(wwin), .wd_timeout_mode_i(wto), .overtemp_warn_i(ovt),
      .supply_below90_i(uv), .supply_active_i(act), .bus_silent_i(sil),
      .trx_uv_deact_i(ev[2]), .txd_dom_timeout_i(ev[1]), .wake_pattern_i(ev[0]),
      .trx_offline_i(off), .reset_output_pin_i(rpin), .rxd_drive_low_o(drv),
      .sys_reset_req_o(rreq));
   eca_mcu_model i_mcu (.rxd_drive_low_i(drv), .rxd_pin_o(pin), .seen_i(seen),
      .clear_mask_o(cmask));

   always #5 mclk_i = ~mclk_i;

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic results;
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      addr = a; wdata = d; wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
      addr = a; rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      seen = rdata;
      chk8(rdata, exp);
   endtask
   // Event pulses, then time for capture to land
   task automatic pulse(input logic [5:0] m);
      ev = m;
      tick(1);
      req_seen = rreq;
      ev = 6'h00;
      tick(4);
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      tick(3);
      arst_n_i = 1'b1;
      foreach (regs[i]) rd_reg(regs[i], 8'h00);
      foreach (regs[i]) wr_reg(regs[i], 8'hFF);
      foreach (regs[i]) rd_reg(regs[i], en_exp[i]);
      for (int i = 0; i < 3; i++) wr_reg(regs[i], 8'h00);
      // Disabled sources must leave no trace
      cnt = 6'h14; done = 1'b1;
      tick(1);
      done = 1'b0;
      pulse(6'h07);
      ovt = 1'b1; uv = 1'b1;
      tick(4);
      for (int i = 4; i < 7; i++) rd_reg(regs[i], 8'h00);
      chk1(pin, 1'b1);
      ovt = 1'b0; uv = 1'b0;
      // Unconditional flags; second timeout overflow resets
      pulse(6'h30);
      chk1(req_seen, 1'b0);
      rd_reg(7'h61, 8'h11);
      rd_reg(7'h60, 8'h01);
      chk1(pin, 1'b0);
      pulse(6'h10);
      chk1(req_seen, 1'b1);
      wto = 1'b0; wwin = 1'b1;
      pulse(6'h08);
      chk1(req_seen, 1'b1);
      wto = 1'b1; wwin = 1'b0;
      // Clear releases the pin; events during the delay stay silent
      rd_reg(7'h61, 8'h11);
      wr_reg(7'h61, cmask & 8'h10);
      chk1(pin, 1'b1);
      pulse(6'h20);
      chk1(pin, 1'b1);
      rd_reg(7'h61, 8'h11);
      tick(6);
      chk1(pin, 1'b0);
      wr_reg(7'h61, 8'h10);
      tick(2);
      wr_reg(7'h61, 8'h01);
      tick(14);
      chk1(pin, 1'b1);
      // Enable all while the bus is active, then serial checks
      wr_reg(7'h04, 8'h06);
      wr_reg(7'h1C, 8'h01);
      wr_reg(7'h23, 8'h13);
      for (int i = 0; i < 6; i++) begin
         cnt = fc[i]; bad = (i == 4); lock = (i == 5); done = 1'b1;
         tick(1);
         done = 1'b0;
         tick(2);
         rd_reg(7'h61, (i > 2) ? 8'h02 : 8'h00);
         wr_reg(7'h61, cmask);
      end
      for (int i = 1; i < 3; i++) begin
         pulse(6'h01 << i);
         rd_reg(7'h63, 8'h02);
         wr_reg(7'h63, cmask);
      end
      pulse(6'h01);
      rd_reg(7'h63, 8'h01);
      ovt = 1'b1; uv = 1'b1; sil = 1'b1;
      tick(4);
      rd_reg(7'h61, 8'h04);
      rd_reg(7'h62, 8'h01);
      rd_reg(7'h63, 8'h11);
      rd_reg(7'h60, 8'h07);
      // Delay runs out and the pending flags pull the pin low again
      tick(12);
      chk1(pin, 1'b0);
      // Leaving offline or losing the supply must release the pin
      off = 1'b0;
      tick(2);
      chk1(pin, 1'b1);
      off = 1'b1;
      act = 1'b0;
      tick(2);
      chk1(pin, 1'b1);
      act = 1'b1;
      tick(2);
      rd_reg(7'h61, 8'h04);
      wr_reg(7'h61, cmask);
      rpin = 1'b0;
      tick(5);
      chk1(pin, 1'b0);
      rpin = 1'b1;
      results();
   end

   // Run needs well under 1000 cycles
   initial begin
      #50000;
      n_mismatch++;
      results();
   end
endmodule
